// ---- shared/sps_map.vh ----
/*
 * Timing constants and reset values for the staged power switch sequencer.
 * Assumes a 50 MHz system clock; included by the sequencer by bare name.
 */
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// Clock rate in kHz
`define SPS_CLK_KHZ         50000
// Debounce interval in ms
`define SPS_DEBOUNCE_MS     25
// Fault timer after current limit in us
`define SPS_ILIM_US         100
// Power-good timer in ms
`define SPS_PGOOD_MS        10
// Bad-transistor timer in ms
`define SPS_FETBAD_MS       20
// Cool-off cycle count of the breaker timer
`define SPS_COOL_CYCLES     512
// Derived cycle counts
`define SPS_DEBOUNCE_CYC    (`SPS_DEBOUNCE_MS * `SPS_CLK_KHZ)
`define SPS_ILIM_CYC        ((`SPS_ILIM_US * `SPS_CLK_KHZ) / 1000)
`define SPS_PGOOD_CYC       (`SPS_PGOOD_MS * `SPS_CLK_KHZ)
`define SPS_FETBAD_CYC      (`SPS_FETBAD_MS * `SPS_CLK_KHZ)
// Default start-up window and breaker timer counts
`define SPS_STARTUP_DEF     32'd1000000
`define SPS_BREAKER_DEF     32'd500000

`endif

// ---- rtl/sps_sync.v ----
/*
 * Two-flop synchroniser for a bundle of asynchronous comparator levels.
 * Assumes the inputs are quasi-static levels from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sps_sync #(
    parameter WIDTH = 12
) (
    input  wire             clock_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second
    always @(posedge clock_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

`default_nettype wire

// ---- rtl/sps_sequencer.v ----
/*
 * Control sequencer of a two-stage supply switch: debounce, short check,
 * start-up gate, handover to bypass gate, power-good timing, fault latching.
 * Assumes comparator results arrive as asynchronous digital levels and that
 * rst_i is asserted while the supply is below undervoltage lockout.
 */
// Summary of operation
// - Both gates stay off until the supply lockout comparator reports good
// - Monitor input rising starts a 25 ms debounce before start-up
// - Drain-to-return below 1.3 V in debounce latches fault at debounce end
// - Clean debounce turns on the start-up gate
// - Start-up window timer starts together with the start-up gate
// - Start-up current limit for 100 us turns gate off and latches fault
// - Bypass gate turns on when start-up gate high and output near input
// - Start-up gate turns off when bypass gate high and drop under 100 mV
// - Start-up window timer clears on successful handover
// - Handover starts 10 ms power-good timer, then power good is released
// - Window expiry before power-good timer latches both gates off
// - Breaker threshold runs breaker timer; expiry turns bypass off, faults
// - Bypass current limit for 100 us turns bypass off and faults
// - After power good, drop or weak gate for 20 ms latches bypass off
// - Bad-transistor fault ignores monitor reset; only lockout clears it
// - Boost request selects doubled breaker and current-limit comparisons
// - Boost request also selects doubled drop threshold for bad-transistor
// - Monitor input below undervoltage threshold turns both gates off
// - After power good, output below 3.7 V turns bypass off and faults
// - Overcurrent turn-off of the bypass gate runs 512 cool-off cycles holding fault asserted
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.vh"

module sps_sequencer #(
    parameter DEBOUNCE_CYC = `SPS_DEBOUNCE_CYC,
    parameter ILIM_CYC     = `SPS_ILIM_CYC,
    parameter PGOOD_CYC    = `SPS_PGOOD_CYC,
    parameter FETBAD_CYC   = `SPS_FETBAD_CYC,
    parameter COOL_CYCLES  = `SPS_COOL_CYCLES
) (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        supply_uvlo_ok_i,
    input  wire        supply_monitor_on_i,
    input  wire        supply_monitor_uv_i,
    input  wire        supply_monitor_reset_i,
    input  wire        drain_short_i,
    input  wire        startup_ilim_i,
    input  wire        startup_gate_high_i,
    input  wire        out_within_1v_i,
    input  wire        bypass_gate_high_i,
    input  wire        drop_below_100mv_i,
    input  wire        drop_below_200mv_i,
    input  wire        breaker_10mv_i,
    input  wire        breaker_20mv_i,
    input  wire        bypass_ilim_15mv_i,
    input  wire        bypass_ilim_30mv_i,
    input  wire        out_below_3v7_i,
    input  wire        surge_boost_request_i,
    input  wire [31:0] startup_window_count_i,
    input  wire [31:0] breaker_count_i,
    output reg         startup_gate_enable_o,
    output reg         bypass_gate_enable_o,
    output wire        fault_n_o,
    output wire        fault_n_oe_o,
    output wire        power_good_out_o,
    output wire        power_good_out_oe_o,
    output wire [5:0]  state_o
);

    localparam [5:0] ST_IDLE     = 6'h01;
    localparam [5:0] ST_DEBOUNCE = 6'h02;
    localparam [5:0] ST_STARTUP  = 6'h04;
    localparam [5:0] ST_BYPASS   = 6'h08;
    localparam [5:0] ST_PGTIME   = 6'h10;
    localparam [5:0] ST_ON       = 6'h20;

    localparam [31:0] DEB_MAX  = DEBOUNCE_CYC;
    localparam [31:0] ILIM_MAX = ILIM_CYC;
    localparam [31:0] PG_MAX   = PGOOD_CYC;
    localparam [31:0] FB_MAX   = FETBAD_CYC;
    localparam [31:0] COOL_FULL = COOL_CYCLES;
    localparam [9:0]  COOL_MAX  = COOL_FULL[9:0];

    // Saturating increment shared by all timers
    function [31:0] inc32;
        input [31:0] v;
        begin
            inc32 = (v == 32'hffffffff) ? v : v + 32'h1;
        end
    endfunction

    // Synchronised comparator levels
    wire [15:0] sync_w;

    sps_sync #(
        .WIDTH (16)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({supply_uvlo_ok_i, supply_monitor_on_i, supply_monitor_uv_i,
                   supply_monitor_reset_i, drain_short_i, startup_ilim_i,
                   startup_gate_high_i, out_within_1v_i, bypass_gate_high_i,
                   drop_below_100mv_i, drop_below_200mv_i, breaker_10mv_i,
                   breaker_20mv_i, bypass_ilim_15mv_i, bypass_ilim_30mv_i,
                   out_below_3v7_i}),
        .sync_o  (sync_w)
    );

    wire uvlo_ok   = sync_w[15];
    wire mon_on    = sync_w[14];
    wire mon_uv    = sync_w[13];
    wire mon_rst   = sync_w[12];
    wire d_short   = sync_w[11];
    wire su_ilim   = sync_w[10];
    wire su_high   = sync_w[9];
    wire near_1v   = sync_w[8];
    wire by_high   = sync_w[7];
    wire drop_100  = sync_w[6];
    wire drop_200  = sync_w[5];
    wire brk_10    = sync_w[4];
    wire brk_20    = sync_w[3];
    wire ilim_15   = sync_w[2];
    wire ilim_30   = sync_w[1];
    wire out_low   = sync_w[0];

    // Boost selects doubled thresholds
    wire brk_hit   = surge_boost_request_i ? brk_20 : brk_10;
    wire ilim_hit  = surge_boost_request_i ? ilim_30 : ilim_15;
    wire drop_ok   = surge_boost_request_i ? drop_200 : drop_100;

    reg  [5:0]  state_q;
    reg  [31:0] deb_q;
    reg  [31:0] win_q;
    reg  [31:0] ilim_q;
    reg  [31:0] pg_q;
    reg  [31:0] fb_q;
    reg  [31:0] brk_q;
    reg         brk_dn_q;
    reg  [9:0]  cool_q;
    reg         cooling_q;
    reg         short_seen_q;
    reg         flt_q;
    reg         flt_bad_q;
    reg         pgood_q;

    wire latched   = flt_q | flt_bad_q;
    wire ilim_run  = (state_q == ST_STARTUP) ? su_ilim :
                     ((state_q == ST_BYPASS) || (state_q == ST_PGTIME) || (state_q == ST_ON)) ? ilim_hit : 1'b0;
    wire by_active = (state_q == ST_BYPASS) || (state_q == ST_PGTIME) || (state_q == ST_ON);
    wire ilim_exp  = ilim_run && (ilim_q >= ILIM_MAX - 32'h1);
    wire brk_exp   = by_active && brk_hit && (brk_q >= breaker_count_i - 32'h1);
    wire win_exp   = (state_q == ST_STARTUP || state_q == ST_BYPASS) &&
                     (win_q >= startup_window_count_i - 32'h1);
    wire fb_run    = (state_q == ST_ON) && (!drop_ok || !by_high);
    wire fb_exp    = fb_run && (fb_q >= FB_MAX - 32'h1);
    wire over_trip = by_active && (ilim_exp || brk_exp);
    wire out_trip  = (state_q == ST_ON) && out_low;

    // Main sequencing state machine
    always @(posedge clock_i) begin
        if (rst_i || !uvlo_ok) begin
            state_q               <= ST_IDLE;
            startup_gate_enable_o <= 1'b0;
            bypass_gate_enable_o  <= 1'b0;
            flt_q                 <= 1'b0;
            flt_bad_q             <= 1'b0;
            pgood_q               <= 1'b0;
            short_seen_q          <= 1'b0;
        end else if (!mon_on || mon_uv) begin
            // Undervoltage turns both gates off
            state_q               <= ST_IDLE;
            startup_gate_enable_o <= 1'b0;
            bypass_gate_enable_o  <= 1'b0;
            pgood_q               <= 1'b0;
            short_seen_q          <= 1'b0;
            if (mon_rst && !cooling_q) begin
                flt_q <= 1'b0;
            end
        end else begin
            case (state_q)
            ST_IDLE: begin
                if (!latched && !cooling_q) begin
                    state_q <= ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                if (d_short) begin
                    short_seen_q <= 1'b1;
                end
                if (deb_q >= DEB_MAX - 32'h1) begin
                    if (short_seen_q || d_short) begin
                        flt_q   <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        startup_gate_enable_o <= 1'b1;
                        state_q               <= ST_STARTUP;
                    end
                end
            end
            ST_STARTUP: begin
                if (ilim_exp || win_exp) begin
                    startup_gate_enable_o <= 1'b0;
                    flt_q                 <= 1'b1;
                    state_q               <= ST_IDLE;
                end else if (su_high && near_1v) begin
                    bypass_gate_enable_o <= 1'b1;
                    state_q              <= ST_BYPASS;
                end
            end
            ST_BYPASS: begin
                if (over_trip || win_exp) begin
                    startup_gate_enable_o <= 1'b0;
                    bypass_gate_enable_o  <= 1'b0;
                    flt_q                 <= 1'b1;
                    state_q               <= ST_IDLE;
                end else if (by_high && drop_100) begin
                    startup_gate_enable_o <= 1'b0;
                    state_q               <= ST_PGTIME;
                end
            end
            ST_PGTIME: begin
                if (over_trip) begin
                    bypass_gate_enable_o <= 1'b0;
                    flt_q                <= 1'b1;
                    state_q              <= ST_IDLE;
                end else if (pg_q >= PG_MAX - 32'h1) begin
                    pgood_q <= 1'b1;
                    state_q <= ST_ON;
                end
            end
            ST_ON: begin
                if (over_trip || out_trip) begin
                    bypass_gate_enable_o <= 1'b0;
                    flt_q                <= 1'b1;
                    pgood_q              <= 1'b0;
                    state_q              <= ST_IDLE;
                end else if (fb_exp) begin
                    bypass_gate_enable_o <= 1'b0;
                    flt_bad_q            <= 1'b1;
                    pgood_q              <= 1'b0;
                    state_q              <= ST_IDLE;
                end
            end
            default: begin
                state_q               <= ST_IDLE;
                startup_gate_enable_o <= 1'b0;
                bypass_gate_enable_o  <= 1'b0;
            end
            endcase
        end
    end

    // Interval timers, each cleared outside its phase
    always @(posedge clock_i) begin
        if (rst_i) begin
            deb_q  <= 32'h0;
            win_q  <= 32'h0;
            ilim_q <= 32'h0;
            pg_q   <= 32'h0;
            fb_q   <= 32'h0;
        end else begin
            deb_q  <= (state_q == ST_DEBOUNCE) ? inc32(deb_q) : 32'h0;
            win_q  <= (state_q == ST_STARTUP || state_q == ST_BYPASS) ? inc32(win_q) : 32'h0;
            ilim_q <= ilim_run ? inc32(ilim_q) : 32'h0;
            pg_q   <= (state_q == ST_PGTIME) ? inc32(pg_q) : 32'h0;
            fb_q   <= fb_run ? inc32(fb_q) : 32'h0;
        end
    end

    // Breaker timer counts up over threshold, down below; then cool-off
    always @(posedge clock_i) begin
        if (rst_i) begin
            brk_q     <= 32'h0;
            brk_dn_q  <= 1'b0;
            cool_q    <= 10'h0;
            cooling_q <= 1'b0;
        end else if (over_trip || out_trip) begin
            // Output collapse is an overcurrent turn-off as well
            brk_q     <= breaker_count_i;
            brk_dn_q  <= 1'b1;
            cool_q    <= 10'h0;
            cooling_q <= 1'b1;
        end else if (cooling_q) begin
            if (brk_dn_q) begin
                brk_q <= (brk_q == 32'h0) ? 32'h0 : brk_q - 32'h1;
                if (brk_q == 32'h0) begin
                    brk_dn_q <= 1'b0;
                    // First ramp-down, then COOL_MAX full up/down cycles
                    if (cool_q == COOL_MAX) begin
                        cooling_q <= 1'b0;
                    end else begin
                        cool_q <= cool_q + 10'h1;
                    end
                end
            end else begin
                brk_q <= inc32(brk_q);
                if (brk_q >= breaker_count_i - 32'h1) begin
                    brk_dn_q <= 1'b1;
                end
            end
        end else if (by_active && brk_hit) begin
            brk_q <= inc32(brk_q);
        end else if (brk_q != 32'h0) begin
            brk_q <= brk_q - 32'h1;
        end
    end

    // Open-drain outputs: fault pulls low, power good released when good
    assign fault_n_o           = 1'b0;
    assign fault_n_oe_o        = latched | cooling_q;
    assign power_good_out_o    = 1'b0;
    assign power_good_out_oe_o = !pgood_q;
    assign state_o             = state_q;

endmodule

`default_nettype wire

// ---- sim/sps_checker.sv ----
/*
 * Checker for the sequencer ports, bound to the sequencer module.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sps_checker #(
    parameter int DEBOUNCE_CYC = 20,
    parameter int PGOOD_CYC    = 10
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        supply_uvlo_ok_i,
    input wire logic        startup_gate_high_i,
    input wire logic        out_within_1v_i,
    input wire logic        bypass_gate_high_i,
    input wire logic        drop_below_100mv_i,
    input wire logic        breaker_10mv_i,
    input wire logic        surge_boost_request_i,
    input wire logic [31:0] startup_window_count_i,
    input wire logic [31:0] breaker_count_i,
    input wire logic        startup_gate_enable_o,
    input wire logic        bypass_gate_enable_o,
    input wire logic        fault_n_oe_o,
    input wire logic        power_good_out_oe_o,
    input wire logic [5:0]  state_o
);
    int win_q;
    int brk_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Cycles in charge states, and of unbroken breaker overload
    always @(posedge clock_i) begin
        win_q <= (!rst_i && (state_o == 6'h04 || state_o == 6'h08)) ? win_q + 1 : 0;
        brk_q <= (!rst_i && breaker_10mv_i && !surge_boost_request_i && bypass_gate_enable_o) ? brk_q + 1 : 0;
    end

    sequence s_both_on;
        startup_gate_enable_o && bypass_gate_enable_o;
    endsequence
    sequence s_handover;
        s_both_on ##1 !startup_gate_enable_o && bypass_gate_enable_o;
    endsequence

    property p_lockout;
        (!supply_uvlo_ok_i) [*4] |-> !startup_gate_enable_o && !bypass_gate_enable_o;
    endproperty
    property p_debounce;
        $rose(startup_gate_enable_o) |->
            $past(state_o, DEBOUNCE_CYC) == 6'h02 && $past(state_o, DEBOUNCE_CYC + 1) != 6'h02;
    endproperty
    property p_start;
        $rose(startup_gate_enable_o) |-> state_o == 6'h04 && !bypass_gate_enable_o && !fault_n_oe_o;
    endproperty
    property p_bypass;
        $rose(bypass_gate_enable_o) |-> startup_gate_enable_o && $past(startup_gate_high_i && out_within_1v_i, 3);
    endproperty
    property p_handover;
        s_handover |-> state_o == 6'h10 && $past(bypass_gate_high_i && drop_below_100mv_i, 3);
    endproperty
    property p_pgood;
        $fell(power_good_out_oe_o) |-> state_o == 6'h20 && $past(state_o, PGOOD_CYC) == 6'h10;
    endproperty
    property p_window;
        win_q <= int'(startup_window_count_i);
    endproperty
    property p_breaker;
        brk_q > int'(breaker_count_i) + 2 |-> !bypass_gate_enable_o && fault_n_oe_o;
    endproperty

    a_lockout: assert property (p_lockout) else $error("gate on in lockout");
    a_debounce: assert property (p_debounce) else $error("debounce length wrong");
    a_start: assert property (p_start) else $error("start-up gate wrong");
    a_bypass: assert property (p_bypass) else $error("bypass gate early");
    a_handover: assert property (p_handover) else $error("handover wrong");
    a_pgood: assert property (p_pgood) else $error("power good timing");
    a_window: assert property (p_window) else $error("window overrun");
    a_breaker: assert property (p_breaker) else $error("breaker missed");
endmodule

bind sps_sequencer sps_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .PGOOD_CYC(PGOOD_CYC)) i_sps_checker (
    .clock_i, .rst_i, .supply_uvlo_ok_i, .startup_gate_high_i, .out_within_1v_i,
    .bypass_gate_high_i, .drop_below_100mv_i, .breaker_10mv_i, .surge_boost_request_i,
    .startup_window_count_i, .breaker_count_i, .startup_gate_enable_o, .bypass_gate_enable_o,
    .fault_n_oe_o, .power_good_out_oe_o, .state_o);

`default_nettype wire

// ---- sim/sps_far_side.sv ----
/*
 * Far side: pass transistors and threshold comparators.
 * Assumes gate enables from the sequencer; lag_i sets charge time.
 */
`timescale 1ns/1ps
`default_nettype none

module sps_far_side (
    input  wire logic       clock_i,
    input  wire logic       startup_gate_enable_i,
    input  wire logic       bypass_gate_enable_i,
    input  wire logic [7:0] lag_i,
    input  wire logic       bad_i,
    output logic            startup_gate_high_o,
    output logic            out_within_1v_o,
    output logic            bypass_gate_high_o,
    output logic            drop_below_100mv_o,
    output logic            drop_below_200mv_o
);
    int s_q = 0;
    int b_q = 0;

    // Gate drive builds while enabled, collapses when released
    always @(posedge clock_i) begin
        s_q <= startup_gate_enable_i ? s_q + 1 : 0;
        b_q <= bypass_gate_enable_i ? b_q + 1 : 0;
    end

    // A bad bypass path shows a drop only over the normal level
    assign startup_gate_high_o = startup_gate_enable_i && s_q > int'(lag_i);
    assign bypass_gate_high_o  = bypass_gate_enable_i && b_q > int'(lag_i);
    assign out_within_1v_o     = startup_gate_high_o || bypass_gate_high_o;
    assign drop_below_100mv_o  = bypass_gate_high_o && !bad_i;
    assign drop_below_200mv_o  = bypass_gate_high_o;
endmodule

`default_nettype wire

// ---- sim/sps_sequencer_tb.sv ----
/*
 * Self-checking bench for the sequencer and its far side.
 * Assumes short timer parameters so each phase is a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module sps_sequencer_tb;
    logic        clock_i, rst_i, uvlo, mon_on, mon_uv, mon_rst, dshort, silim, boost;
    logic [5:0]  f;
    logic [7:0]  lag;
    logic [31:0] win, brk;
    wire  [5:0]  st;
    wire         sg_en, bg_en, flt_oe, pg_oe, sgh, w1v, bgh, d100, d200, flt_d, pg_d;
    // Fault pin level with its pull-up
    wire         flt_pin = flt_oe ? flt_d : 1'b1;
    int          failures, n_checks, k;

    sps_sequencer #(.DEBOUNCE_CYC(20), .ILIM_CYC(5), .PGOOD_CYC(10), .FETBAD_CYC(10), .COOL_CYCLES(4))
    i_sps_sequencer (.clock_i, .rst_i, .supply_uvlo_ok_i(uvlo), .supply_monitor_on_i(mon_on),
        .supply_monitor_uv_i(mon_uv), .supply_monitor_reset_i(mon_rst), .drain_short_i(dshort),
        .startup_ilim_i(silim), .startup_gate_high_i(sgh), .out_within_1v_i(w1v),
        .bypass_gate_high_i(bgh), .drop_below_100mv_i(d100), .drop_below_200mv_i(d200),
        .breaker_10mv_i(f[0]), .breaker_20mv_i(f[1]), .bypass_ilim_15mv_i(f[2]),
        .bypass_ilim_30mv_i(f[3]), .out_below_3v7_i(f[4]), .surge_boost_request_i(boost),
        .startup_window_count_i(win), .breaker_count_i(brk), .startup_gate_enable_o(sg_en),
        .bypass_gate_enable_o(bg_en), .fault_n_o(flt_d), .fault_n_oe_o(flt_oe), .power_good_out_o(pg_d),
        .power_good_out_oe_o(pg_oe), .state_o(st));

    sps_far_side i_sps_far_side (.clock_i, .startup_gate_enable_i(sg_en), .bypass_gate_enable_i(bg_en),
        .lag_i(lag), .bad_i(f[5]), .startup_gate_high_o(sgh), .out_within_1v_o(w1v),
        .bypass_gate_high_o(bgh), .drop_below_100mv_o(d100), .drop_below_200mv_o(d200));

    // Free-running 50 MHz clock
    initial begin
        clock_i = 0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        n_checks++;
        if (c !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Bounded wait for a state; k returns the cycles taken
    task automatic wait_st(input logic [5:0] s, input int n);
        k = 0;
        while (st !== s && k < n) begin
            cyc(1);
            k++;
        end
        chk(st === s, "state not reached");
        if (st !== s)
            summarize();
    endtask

    // Drop the monitor into reset and wait for the fault to clear
    task automatic clear(input bit hard);
        f = 0;
        boost = 0;
        silim = 0;
        dshort = 0;
        mon_on = 0;
        mon_rst = 1;
        cyc(5);
        if (hard) begin
            cyc(60);
            chk(flt_oe === 1'b1, "fault cleared by monitor");
            uvlo = 0;
            cyc(6);
            uvlo = 1;
        end
        k = 0;
        while (flt_oe !== 1'b0 && k < 600) begin
            cyc(1);
            k++;
        end
        chk(flt_oe === 1'b0 && st === 6'h01, "fault not cleared");
        mon_rst = 0;
        cyc(3);
    endtask

    // Expected state walk with its timed phases
    task automatic power_up;
        logic [5:0] seq[$];
        int         dur[$];
        seq = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
        dur = '{0, 20, 0, 0, 10};
        lag = 8'($urandom_range(2, 9));
        mon_on = 1;
        foreach (seq[i]) begin
            wait_st(seq[i], 60);
            if (dur[i] > 0)
                chk(k == dur[i], "phase length");
        end
        chk(sg_en === 1'b0 && bg_en === 1'b1 && pg_oe === 1'b0, "on outputs");
    endtask

    // Start-up that never charges: window expiry or current limit
    task automatic stall(input logic il, input int lim);
        clear(0);
        lag = 8'hc8;
        mon_on = 1;
        wait_st(6'h04, 40);
        silim = il;
        k = 0;
        while (sg_en !== 1'b0 && k < lim) begin
            cyc(1);
            k++;
        end
        chk(flt_oe === 1'b1 && bg_en === 1'b0 && k >= (il ? 5 : int'(win) - 3), "start abort");
    endtask

    // Overload after power good, with or without a trip expected
    task automatic trip(input logic [5:0] bits, input logic b, input bit hit, input int lim);
        clear(0);
        power_up();
        boost = b;
        f = bits;
        k = 0;
        while (flt_oe !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
        chk(flt_oe === hit && bg_en === !hit, "trip outcome");
        if (hit && !bits[5]) begin
            f = 0;
            k = 0;
            // Fault pin wired back to the monitor input: retry after cool-off
            while (st !== 6'h02 && k < 600) begin
                mon_on  = flt_pin;
                mon_rst = !flt_pin;
                cyc(1);
                k++;
                if (k == 4)
                    chk(flt_oe === 1'b1, "cool-off not held");
            end
            chk(st === 6'h02, "no automatic retry");
        end
        clear(hit && bits[5]);
    endtask

    // Main sequence
    initial begin
        {uvlo, mon_on, mon_uv, mon_rst, dshort, silim, boost} = 0;
        f = 0;
        lag = 8'h02;
        win = 32'h28;
        brk = 32'h8;
        rst_i = 1;
        failures = 0;
        n_checks = 0;
        k = $urandom(19026);
        cyc(10);
        chk(sg_en === 1'b0 && bg_en === 1'b0 && pg_oe === 1'b1 && flt_oe === 1'b0 &&
            pg_d === 1'b0 && flt_d === 1'b0, "reset");
        rst_i = 0;
        mon_on = 1;
        cyc(40);
        chk(st === 6'h01 && sg_en === 1'b0, "start in lockout");
        uvlo = 1;
        win = 32'(40 + $urandom_range(0, 15));
        brk = 32'($urandom_range(6, 12));
        clear(0);
        dshort = 1;
        mon_on = 1;
        wait_st(6'h02, 10);
        cyc(10);
        chk(flt_oe === 1'b0, "early short fault");
        cyc(15);
        chk(flt_oe === 1'b1 && sg_en === 1'b0, "short missed");
        stall(1'b0, 80);
        stall(1'b1, 20);
        trip(6'h01, 0, 1, 30);
        trip(6'h01, 1, 0, 40);
        trip(6'h04, 0, 1, 20);
        trip(6'h04, 1, 0, 30);
        trip(6'h20, 1, 0, 40);
        trip(6'h20, 0, 1, 30);
        trip(6'h10, 0, 1, 8);
        power_up();
        mon_uv = 1;
        cyc(5);
        chk(sg_en === 1'b0 && bg_en === 1'b0 && st === 6'h01, "gates on in undervoltage");
        summarize();
    end
endmodule

`default_nettype wire
